// *** rtl/pfrc_codec.sv ***
// XOR parity repair encoder and header rebuilder for one lost packet
// Assumes same-clock stream logic on both sides and a one-cycle register master
//
// Contract
// (R1) Per-packet string: 64 header bits, length-12
// (R2) Repair string is XOR of member strings
// (R3) Drop top two bits, insert MSK
// (R4) Then P, X, CC, M, PT recovery
// (R5) Skip 16 bits, then 32-bit timestamp
// (R6) Last 16 bits length, then bitmask
// (R7) Header 12 octets, up to 28
// (R8) Bitmask mode: SN base lowest marked
// (R9) No mask: SN base lowest row/column
// (R10) Payload XOR, zero-padded to longest
// (R11) Results identical to reference procedures
// (R12) Column D members, row L members
// (R13) Recover only with exactly one missing
// (R14) Out-of-band: base plus i times step
// (R15) Repair payload type selects interleaving
// (R16) Mask ones are offsets from base
// (R17) M/N offsets define protected numbers
// (R18) XOR received strings with repair 80 bits
// (R19) Version 2, drop two bits
// (R20) Then P, X, CC, M, PT rebuilt
// (R21) SN is lost number, TS follows
// (R22) Length minus 12; SSRC from stream
// (R23) Two or more missing: flag, skip
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "pfrc_map.svh"

module pfrc_codec #(
    parameter int PAY_WORDS = 16,
    parameter int SPAN = 128
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    // Register port
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    // Source packets
    input wire logic SRC_VALID_IN,
    input wire logic [63:0] SRC_HDR_IN,
    input wire logic [15:0] SRC_LEN_IN,
    input wire logic SRC_PAY_VALID_IN,
    input wire logic [$clog2(PAY_WORDS)-1:0] SRC_PAY_IDX_IN,
    input wire logic [31:0] SRC_PAY_DATA_IN,
    // Received repair packet
    input wire logic REP_VALID_IN,
    input wire logic [223:0] REP_HDR_IN,
    input wire logic [6:0] REP_PT_IN,
    // Generated repair header
    output logic FEC_VALID_OUT,
    output logic [223:0] FEC_HDR_OUT,
    output logic [4:0] FEC_BYTES_OUT,
    // Rebuilt header
    output logic REC_VALID_OUT,
    output logic [95:0] REC_HDR_OUT,
    output logic [15:0] REC_LEN_OUT,
    output logic UNREC_OUT,
    output logic DEC_BUSY_OUT
);
    import pfrc_pkg::*;

    localparam int IW = $clog2(PAY_WORDS);
    localparam int OW = $clog2(SPAN);
    localparam int MB = `PFRC_MASK_BITS;

    typedef struct packed {
        logic enc_en;
        logic enc_inter;
        logic [1:0] enc_msk;
        logic [7:0] grp_l;
        logic [7:0] grp_d;
        logic [31:0] ssrc;
        logic [6:0] inter_pt;
        logic [IW-1:0] pay_idx;
        logic st_fec;
        logic st_rec;
        logic st_unrec;
        logic [31:0] rd_data;
        logic [79:0] e_acc;
        logic [7:0] e_cnt;
        logic [15:0] e_base;
        logic [MB-1:0] e_mask;
        logic [15:0] e_maxlen;
        logic pay_fresh;
        logic [PAY_WORDS-1:0][31:0] pay;
        logic fec_valid;
        logic [223:0] fec_hdr;
        logic [4:0] fec_bytes;
        logic [15:0] fec_paylen;
        pfrc_dec_t dstate;
        logic busy;
        logic [79:0] d_acc;
        logic [15:0] d_base;
        logic [7:0] d_step;
        logic [8:0] d_cnt;
        logic [8:0] d_i;
        logic [16:0] d_off;
        logic [SPAN-1:0] d_exp;
        logic [SPAN-1:0] d_rcv;
        logic rec_valid;
        logic [95:0] rec_hdr;
        logic [15:0] rec_len;
        logic unrec;
    } pfrc_state_t;

    pfrc_state_t st_ff;
    pfrc_state_t nxt_st;

    logic [79:0] src_bits;
    logic [15:0] src_sn;
    logic [15:0] src_off;
    logic src_hit;
    logic [7:0] grp_size;
    logic [79:0] enc_acc;
    logic enc_last;
    logic enc_first;
    logic [15:0] enc_base;
    logic [15:0] enc_off;
    logic [MB-1:0] enc_mask;
    logic [15:0] pay_bytes;
    logic [SPAN-1:0] miss;
    logic [1:0] miss_cls;
    logic [1:0] rep_msk;
    logic [7:0] rep_m;
    logic [7:0] rep_n;
    logic rep_inter;
    logic cmd_finish;

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RESET_IN);

    // ==========================================================
    // Helpers
    function automatic logic [79:0] bit_string(input logic [63:0] hdr,
                                              input logic [15:0] len);
        bit_string = {hdr, len - `PFRC_RTP_FIXED};
    endfunction

    function automatic logic [MB-1:0] mask_width(input logic [MB-1:0] m,
                                                input logic [1:0] msk);
        int w;
        w = (msk == 2'h0) ? `PFRC_MASK_W0 : (msk == 2'h1) ? `PFRC_MASK_W1 :
            (msk == `PFRC_MSK_NONE) ? 0 : MB;
        mask_width = m;
        for (int i = 0; i < MB; i++) begin
            if (MB - 1 - i >= w) begin
                mask_width[i] = 1'b0;
            end
        end
    endfunction

    function automatic logic [4:0] hdr_bytes(input logic [1:0] msk);
        hdr_bytes = (msk == 2'h1) ? `PFRC_HDR_B1 :
                    (msk == 2'h2) ? `PFRC_HDR_B2 : `PFRC_HDR_B0;
    endfunction

    // Offset 0 is the base itself; mask MSB is offset 1
    function automatic logic [SPAN-1:0] mask_offsets(input logic [MB-1:0] m);
        mask_offsets = '0;
        mask_offsets[0] = 1'b1;
        for (int k = 1; k <= MB; k++) begin
            mask_offsets[k] = m[MB-k];
        end
    endfunction

    // Saturates at two: only none, one or several matter
    function automatic logic [1:0] miss_class(input logic [SPAN-1:0] v);
        miss_class = 2'h0;
        for (int i = 0; i < SPAN; i++) begin
            if (v[i]) begin
                miss_class = (miss_class == 2'h0) ? 2'h1 : 2'h2;
            end
        end
    endfunction

    function automatic logic [OW-1:0] low_index(input logic [SPAN-1:0] v);
        low_index = '0;
        for (int i = SPAN - 1; i >= 0; i--) begin
            if (v[i]) begin
                low_index = OW'(i);
            end
        end
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        src_bits = bit_string(SRC_HDR_IN, SRC_LEN_IN); // R1
        src_sn = SRC_HDR_IN[47:32];
        pay_bytes = SRC_LEN_IN - `PFRC_RTP_FIXED;
        grp_size = st_ff.enc_inter ? st_ff.grp_d : st_ff.grp_l; // R12
        enc_first = (st_ff.e_cnt == 8'h00);
        enc_acc = (enc_first ? 80'h0 : st_ff.e_acc) ^ src_bits; // R2
        enc_last = (st_ff.e_cnt + 8'h01) >= grp_size;
        enc_base = enc_first ? src_sn : st_ff.e_base; // R8 R9
        enc_off = src_sn - enc_base;
        enc_mask = enc_first ? '0 : st_ff.e_mask;
        src_off = src_sn - st_ff.d_base;
        src_hit = (src_off < 16'(SPAN)) && st_ff.d_exp[src_off[OW-1:0]] &&
                  !st_ff.d_rcv[src_off[OW-1:0]]; // R11
        miss = st_ff.d_exp & ~st_ff.d_rcv;
        miss_cls = miss_class(miss);
        rep_msk = REP_HDR_IN[223:222];
        rep_m = REP_HDR_IN[143:136];
        rep_n = REP_HDR_IN[135:128];
        rep_inter = (REP_PT_IN == st_ff.inter_pt); // R15
        cmd_finish = REG_WR_IN && (REG_ADDR_IN == `PFRC_REG_DEC_CMD) &&
                     REG_WDATA_IN[`PFRC_CMD_FINISH];
        nxt_st.rd_data = 32'h0;
        nxt_st.fec_valid = 1'b0;
        nxt_st.rec_valid = 1'b0;
        nxt_st.unrec = 1'b0;

        // ======================================================
        // Register writes
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                `PFRC_REG_CTRL: begin
                    nxt_st.enc_en = REG_WDATA_IN[`PFRC_CTRL_ENC_EN];
                    nxt_st.enc_inter = REG_WDATA_IN[`PFRC_CTRL_INTER];
                    nxt_st.enc_msk = REG_WDATA_IN[`PFRC_CTRL_MSK_HI:`PFRC_CTRL_MSK_LO];
                end
                `PFRC_REG_GEOM: begin
                    nxt_st.grp_l = REG_WDATA_IN[7:0];
                    nxt_st.grp_d = REG_WDATA_IN[15:8];
                end
                `PFRC_REG_SSRC: begin
                    nxt_st.ssrc = REG_WDATA_IN;
                end
                `PFRC_REG_PTCFG: begin
                    nxt_st.inter_pt = REG_WDATA_IN[6:0];
                end
                `PFRC_REG_PAY_IDX: begin
                    nxt_st.pay_idx = REG_WDATA_IN[IW-1:0];
                end
                `PFRC_REG_STATUS: begin
                    // Write one to clear; hardware sets below win
                    nxt_st.st_fec = st_ff.st_fec & ~REG_WDATA_IN[`PFRC_ST_FEC];
                    nxt_st.st_rec = st_ff.st_rec & ~REG_WDATA_IN[`PFRC_ST_REC];
                    nxt_st.st_unrec = st_ff.st_unrec & ~REG_WDATA_IN[`PFRC_ST_UNREC];
                end
                default: begin
                end
            endcase
        end

        // ======================================================
        // Register reads, data in the next cycle only
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                `PFRC_REG_CTRL: begin
                    nxt_st.rd_data = {28'h0, st_ff.enc_msk, st_ff.enc_inter, st_ff.enc_en};
                end
                `PFRC_REG_GEOM: begin
                    nxt_st.rd_data = {16'h0, st_ff.grp_d, st_ff.grp_l};
                end
                `PFRC_REG_SSRC: begin
                    nxt_st.rd_data = st_ff.ssrc;
                end
                `PFRC_REG_PTCFG: begin
                    nxt_st.rd_data = {25'h0, st_ff.inter_pt};
                end
                `PFRC_REG_STATUS: begin
                    nxt_st.rd_data = {28'h0, st_ff.busy, st_ff.st_unrec, st_ff.st_rec,
                                      st_ff.st_fec};
                end
                `PFRC_REG_PAY_IDX: begin
                    nxt_st.rd_data = 32'(st_ff.pay_idx);
                end
                `PFRC_REG_PAY_DATA: begin
                    nxt_st.rd_data = st_ff.pay[st_ff.pay_idx];
                end
                `PFRC_REG_PAY_LEN: begin
                    nxt_st.rd_data = {16'h0, st_ff.fec_paylen};
                end
                default: begin
                    nxt_st.rd_data = 32'h0;
                end
            endcase
        end

        // ======================================================
        // Encoder payload; buffer is reused by the next group, read it first
        if (st_ff.enc_en && SRC_PAY_VALID_IN) begin
            for (int w = 0; w < PAY_WORDS; w++) begin
                nxt_st.pay[w] = (st_ff.pay_fresh ? 32'h0 : st_ff.pay[w]) ^
                                ((IW'(w) == SRC_PAY_IDX_IN) ? SRC_PAY_DATA_IN : 32'h0); // R10
            end
            nxt_st.pay_fresh = 1'b0;
        end

        // ======================================================
        // Encoder header, one beat per source packet
        if (st_ff.enc_en && SRC_VALID_IN) begin
            if (st_ff.pay_fresh && !SRC_PAY_VALID_IN) begin
                nxt_st.pay = '0; // R10
                nxt_st.pay_fresh = 1'b0;
            end
            if (!enc_first && enc_off != 16'h0 && enc_off <= 16'(MB)) begin
                enc_mask[MB - int'(enc_off)] = 1'b1; // R16
            end
            nxt_st.e_maxlen = (enc_first || pay_bytes > st_ff.e_maxlen) ?
                              pay_bytes : st_ff.e_maxlen; // R10
            nxt_st.e_acc = enc_acc;
            nxt_st.e_base = enc_base;
            nxt_st.e_mask = enc_mask;
            if (enc_last) begin
                nxt_st.e_cnt = 8'h00;
                nxt_st.pay_fresh = 1'b1;
                nxt_st.fec_valid = 1'b1;
                nxt_st.st_fec = 1'b1;
                nxt_st.fec_paylen = nxt_st.e_maxlen;
                nxt_st.fec_bytes = hdr_bytes(st_ff.enc_msk); // R7
                // Base sits in the skipped sequence slot
                nxt_st.fec_hdr = {st_ff.enc_msk, enc_acc[77:64], // R3 R4
                                  enc_base, enc_acc[47:16], // R5 R8 R9
                                  enc_acc[15:0], mask_width(enc_mask, st_ff.enc_msk), // R6
                                  32'h0};
            end else begin
                nxt_st.e_cnt = st_ff.e_cnt + 8'h01;
            end
        end

        // ======================================================
        // Decoder
        case (st_ff.dstate)
            DEC_IDLE: begin
            end
            DEC_BUILD: begin
                if (st_ff.d_off < 17'(SPAN)) begin
                    nxt_st.d_exp[st_ff.d_off[OW-1:0]] = 1'b1; // R14 R17
                end
                nxt_st.d_off = st_ff.d_off + {9'h0, st_ff.d_step};
                nxt_st.d_i = st_ff.d_i + 9'h001;
                if (st_ff.d_i + 9'h001 >= st_ff.d_cnt) begin
                    nxt_st.dstate = DEC_COLLECT;
                end
            end
            DEC_COLLECT: begin
                if (SRC_VALID_IN && src_hit) begin
                    nxt_st.d_rcv[src_off[OW-1:0]] = 1'b1;
                    nxt_st.d_acc = st_ff.d_acc ^ src_bits; // R18
                end
                if (cmd_finish) begin
                    nxt_st.dstate = DEC_EVAL;
                end
            end
            DEC_EVAL: begin
                nxt_st.dstate = DEC_IDLE;
                if (miss_cls == 2'h1) begin // R13
                    nxt_st.rec_valid = 1'b1;
                    nxt_st.st_rec = 1'b1;
                    nxt_st.rec_hdr = {`PFRC_RTP_VER, st_ff.d_acc[77:64], // R19 R20
                                      st_ff.d_base + 16'(low_index(miss)), // R21
                                      st_ff.d_acc[47:16], st_ff.ssrc}; // R21 R22
                    nxt_st.rec_len = st_ff.d_acc[15:0] + `PFRC_RTP_FIXED; // R22
                end else if (miss_cls == 2'h2) begin
                    nxt_st.unrec = 1'b1; // R23
                    nxt_st.st_unrec = 1'b1;
                end
            end
            default: begin
                nxt_st.dstate = DEC_IDLE;
            end
        endcase

        // A new repair packet restarts the decoder
        if (REP_VALID_IN) begin
            nxt_st.d_acc = REP_HDR_IN[223:144]; // R18
            nxt_st.d_base = REP_HDR_IN[207:192];
            nxt_st.d_rcv = '0;
            nxt_st.d_exp = '0;
            nxt_st.d_off = 17'h0;
            nxt_st.d_i = 9'h0;
            if (rep_msk != `PFRC_MSK_NONE) begin
                nxt_st.d_exp = mask_offsets(mask_width(REP_HDR_IN[143:32], rep_msk)); // R16
                nxt_st.dstate = DEC_COLLECT;
            end else if (rep_m != 8'h00) begin
                nxt_st.d_step = (rep_n == 8'h00) ? 8'h01 : rep_m; // R17
                nxt_st.d_cnt = {1'b0, (rep_n == 8'h00) ? rep_m : rep_n} + 9'h001;
                nxt_st.dstate = DEC_BUILD;
            end else begin
                nxt_st.d_step = rep_inter ? st_ff.grp_l : 8'h01; // R14 R15
                nxt_st.d_cnt = {1'b0, rep_inter ? st_ff.grp_d : st_ff.grp_l}; // R12
                nxt_st.dstate = DEC_BUILD;
            end
        end
        nxt_st.busy = (nxt_st.dstate != DEC_IDLE);
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            st_ff <= '0;
            st_ff.grp_l <= `PFRC_RST_GROUP;
            st_ff.grp_d <= `PFRC_RST_GROUP;
            st_ff.pay_fresh <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign REG_RDATA_OUT = st_ff.rd_data;
    assign FEC_VALID_OUT = st_ff.fec_valid;
    assign FEC_HDR_OUT = st_ff.fec_hdr;
    assign FEC_BYTES_OUT = st_ff.fec_bytes;
    assign REC_VALID_OUT = st_ff.rec_valid;
    assign REC_HDR_OUT = st_ff.rec_hdr;
    assign REC_LEN_OUT = st_ff.rec_len;
    assign UNREC_OUT = st_ff.unrec;
    assign DEC_BUSY_OUT = st_ff.busy;

    // ==========================================================
    // Checks
    sequence s_eval_one;
        st_ff.dstate == DEC_EVAL && miss_cls == 2'h1;
    endsequence
    sequence s_eval_many;
        st_ff.dstate == DEC_EVAL && miss_cls == 2'h2;
    endsequence
    sequence s_enc_close;
        st_ff.enc_en && SRC_VALID_IN && enc_last;
    endsequence

    property p_one_missing;
        s_eval_one |=> REC_VALID_OUT && !UNREC_OUT;
    endproperty
    a_one_missing: assert property (p_one_missing) // R13
        else $error("single loss not rebuilt");

    property p_rec_cause;
        REC_VALID_OUT |-> $past(st_ff.dstate) == DEC_EVAL && $past(miss_cls) == 2'h1;
    endproperty
    a_rec_cause: assert property (p_rec_cause) // R13
        else $error("rebuild without exactly one loss");

    property p_many_missing;
        s_eval_many |=> UNREC_OUT && !REC_VALID_OUT;
    endproperty
    a_many_missing: assert property (p_many_missing) // R23
        else $error("multiple losses not flagged");

    property p_rec_fixed;
        REC_VALID_OUT |-> REC_HDR_OUT[95:94] == `PFRC_RTP_VER &&
            REC_HDR_OUT[31:0] == $past(st_ff.ssrc);
    endproperty
    a_rec_fixed: assert property (p_rec_fixed) // R19
        else $error("rebuilt version or stream id wrong");

    property p_rec_len;
        REC_VALID_OUT |-> REC_LEN_OUT == $past(st_ff.d_acc[15:0]) + `PFRC_RTP_FIXED;
    endproperty
    a_rec_len: assert property (p_rec_len) // R22
        else $error("rebuilt length wrong");

    property p_fec_msk;
        FEC_VALID_OUT |-> FEC_HDR_OUT[223:222] == $past(st_ff.enc_msk) &&
            FEC_BYTES_OUT == hdr_bytes($past(st_ff.enc_msk));
    endproperty
    a_fec_msk: assert property (p_fec_msk) // R3 R7
        else $error("repair mask field or size wrong");

    property p_fec_close;
        s_enc_close |=> FEC_VALID_OUT && st_ff.e_cnt == 8'h00;
    endproperty
    a_fec_close: assert property (p_fec_close) // R12
        else $error("group not closed at its size");

    property p_fec_len;
        FEC_VALID_OUT |-> FEC_HDR_OUT[159:144] == $past(enc_acc[15:0]);
    endproperty
    a_fec_len: assert property (p_fec_len) // R6
        else $error("length recovery field wrong");

    property p_build_bound;
        st_ff.dstate == DEC_BUILD |-> ##[1:257] st_ff.dstate != DEC_BUILD;
    endproperty
    a_build_bound: assert property (p_build_bound) // R14
        else $error("member list build overran");

endmodule // pfrc_codec

// *** shared/pfrc_map.svh ***
// Register offsets, field positions, reset values and header sizes of the codec
// Definitions only; included by the codec
`ifndef PFRC_MAP_SVH
`define PFRC_MAP_SVH
// ==========================================================
// Register offsets
`define PFRC_REG_CTRL 8'h00
`define PFRC_REG_GEOM 8'h04
`define PFRC_REG_SSRC 8'h08
`define PFRC_REG_PTCFG 8'h0c
`define PFRC_REG_STATUS 8'h10
`define PFRC_REG_PAY_IDX 8'h14
`define PFRC_REG_PAY_DATA 8'h18
`define PFRC_REG_PAY_LEN 8'h1c
`define PFRC_REG_DEC_CMD 8'h20
// ==========================================================
// Field positions
`define PFRC_CTRL_ENC_EN 0
`define PFRC_CTRL_INTER 1
`define PFRC_CTRL_MSK_LO 2
`define PFRC_CTRL_MSK_HI 3
`define PFRC_ST_FEC 0
`define PFRC_ST_REC 1
`define PFRC_ST_UNREC 2
`define PFRC_CMD_FINISH 0
// ==========================================================
// Reset values
`define PFRC_RST_GROUP 8'h01
// ==========================================================
// Header constants
`define PFRC_MSK_NONE 2'h3
`define PFRC_MASK_BITS 112
`define PFRC_MASK_W0 16
`define PFRC_MASK_W1 48
`define PFRC_HDR_B0 5'h0c
`define PFRC_HDR_B1 5'h10
`define PFRC_HDR_B2 5'h1c
`define PFRC_RTP_FIXED 16'h000c
`define PFRC_RTP_VER 2'h2
`endif

// *** shared/pfrc_pkg.sv ***
// Types shared by the parity repair codec
// No dependencies
package pfrc_pkg;
    // ==========================================================
    // Decoder sequencing
    typedef enum logic [1:0] {
        DEC_IDLE,
        DEC_BUILD,
        DEC_COLLECT,
        DEC_EVAL
    } pfrc_dec_t;
endpackage

// *** verif/pfrc_codec_tb_top.sv ***
// Bench for the parity repair codec: encode groups, rebuild a lost header
// Assumes the stream model beside it and the codec's default parameters
`timescale 1ns/1ps
`include "pfrc_map.svh"
module pfrc_codec_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0, rd = 1'b0, rd_pend = 1'b0;
    logic [31:0] rdata, spd;
    logic sv, spv, rv, fv, recv, unrec, busy;
    logic [63:0] sh;
    logic [15:0] sl, rlen;
    logic [3:0] spi;
    logic [223:0] rh, fh;
    logic [6:0] rpt;
    logic [4:0] fb;
    logic [95:0] rech;
    logic [223:0] q_fec[$];
    logic [4:0] q_fb[$];
    logic [111:0] q_rec[$];
    logic [31:0] q_rd[$];
    int q_unrec = 0;
    int mismatches = 0;
    int checks_done = 0;
    always #4 clk = ~clk;
    pfrc_codec pfrc_codec_inst (.CLK_SYS_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .SRC_VALID_IN(sv), .SRC_HDR_IN(sh), .SRC_LEN_IN(sl), .SRC_PAY_VALID_IN(spv),
        .SRC_PAY_IDX_IN(spi), .SRC_PAY_DATA_IN(spd), .REP_VALID_IN(rv), .REP_HDR_IN(rh),
        .REP_PT_IN(rpt), .FEC_VALID_OUT(fv), .FEC_HDR_OUT(fh), .FEC_BYTES_OUT(fb),
        .REC_VALID_OUT(recv), .REC_HDR_OUT(rech), .REC_LEN_OUT(rlen), .UNREC_OUT(unrec),
        .DEC_BUSY_OUT(busy));
    pfrc_stream_model pfrc_stream_model_inst (.clk_in(clk), .src_valid_out(sv),
        .src_hdr_out(sh), .src_len_out(sl), .src_pay_valid_out(spv), .src_pay_idx_out(spi),
        .src_pay_data_out(spd), .rep_valid_out(rv), .rep_hdr_out(rh), .rep_pt_out(rpt));
    // ==========================================================
    // Checking
    task automatic check(input string n, input logic [255:0] s, e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        rd_pend <= rd;
        if (rd_pend) check("rdata", rdata, q_rd.pop_front());
        if (fv) begin
            check("fec_hdr", fh, q_fec.pop_front());
            check("fec_bytes", fb, q_fb.pop_front());
        end
        if (recv) check("rec", {rlen, rech}, q_rec.pop_front());
        if (recv || unrec) check("idle", 256'(busy), 256'h0);
        if (unrec) begin
            check("unrec", 256'(q_unrec > 0), 256'h1);
            q_unrec--;
        end
    end
    // ==========================================================
    // Register bus and waits
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        q_rd.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while ((q_fec.size() + q_rec.size() + q_rd.size() + q_unrec) != 0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n == 40) begin
            mismatches++;
            give_verdict();
        end
    endtask
    // ==========================================================
    // Scenarios
    initial begin
        logic [63:0] ha, hb;
        logic [79:0] x;
        logic [31:0] a0, a1, b0, ssrc;
        logic [15:0] base;
        void'($urandom(32'hd3920a8d));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // L=2, D=2: interleaved decode steps by two
        wr_reg(`PFRC_REG_GEOM, 32'h0000_0202);
        // Row of two, every MSK value; second packet has the shorter payload
        for (int m = 0; m < 4; m++) begin
            base = 16'($urandom);
            ha = {$urandom, $urandom};
            ha[47:32] = base;
            hb = {$urandom, $urandom};
            hb[47:32] = base + 16'h1;
            a0 = $urandom;
            a1 = $urandom;
            b0 = $urandom;
            wr_reg(`PFRC_REG_CTRL, {28'h0, m[1:0], 2'h1});
            x = {ha, 16'h0008} ^ {hb, 16'h0004};
            q_fec.push_back({m[1:0], x[77:64], base, x[47:0], m != 3, 111'h0, 32'h0});
            q_fb.push_back(m == 1 ? 5'h10 : (m == 2 ? 5'h1c : 5'h0c));
            pfrc_stream_model_inst.send_src(ha, 16'h0014, a0, a1, 2);
            pfrc_stream_model_inst.send_src(hb, 16'h0010, b0, 32'h0, 1);
            drain();
        end
        rd_reg(`PFRC_REG_PAY_LEN, 32'h8);
        wr_reg(`PFRC_REG_PAY_IDX, 32'h0);
        rd_reg(`PFRC_REG_PAY_DATA, a0 ^ b0);
        wr_reg(`PFRC_REG_PAY_IDX, 32'h1);
        rd_reg(`PFRC_REG_PAY_DATA, a1);
        rd_reg(8'hfc, 32'h0);
        // Mask sets (one lost, then two lost), then M/N and interleaved out-of-band sets
        wr_reg(`PFRC_REG_CTRL, 32'h0);
        ssrc = $urandom;
        wr_reg(`PFRC_REG_SSRC, ssrc);
        for (int u = 0; u < 4; u++) begin
            base = 16'($urandom);
            x = {16'($urandom), $urandom, $urandom};
            ha = {$urandom, $urandom};
            ha[47:32] = base;
            pfrc_stream_model_inst.send_rep({(u > 1) ? 2'h3 : 2'h0, x[77:64], base, x[47:0],
                (u == 0) ? 16'h8000 : (u == 1) ? 16'hc000 : (u == 2) ? 16'h0100 : 16'h0,
                128'h0}, 7'h0);
            @(negedge clk);
            check("busy", 256'(busy), 256'h1);
            // Out-of-band member list build takes two cycles (mask sets go straight to collect); sources before it are dropped
            repeat (2) @(posedge clk);
            pfrc_stream_model_inst.send_src(ha, 16'h0020, 32'h0, 32'h0, 0);
            x = x ^ {ha, 16'h0014};
            if (u == 1) q_unrec++;
            else q_rec.push_back({x[15:0] + 16'h000c, 2'h2, x[77:64],
                base + ((u == 3) ? 16'h2 : 16'h1), x[47:16], ssrc});
            wr_reg(`PFRC_REG_DEC_CMD, 32'h1);
            drain();
        end
        rd_reg(`PFRC_REG_STATUS, 32'h7);
        wr_reg(`PFRC_REG_STATUS, 32'h7);
        rd_reg(`PFRC_REG_STATUS, 32'h0);
        drain();
        give_verdict();
    end
endmodule // pfrc_codec_tb_top

// *** verif/pfrc_stream_model.sv ***
// Stream partner of the codec: source packets with payload, repair packets
// Driven by task calls from the bench, on the codec clock
`timescale 1ns/1ps
module pfrc_stream_model (
    // Clock
    input wire logic clk_in,
    // Source side
    output logic src_valid_out,
    output logic [63:0] src_hdr_out,
    output logic [15:0] src_len_out,
    output logic src_pay_valid_out,
    output logic [3:0] src_pay_idx_out,
    output logic [31:0] src_pay_data_out,
    // Repair side
    output logic rep_valid_out,
    output logic [223:0] rep_hdr_out,
    output logic [6:0] rep_pt_out
);
    // ==========================================================
    // Idle lines
    initial begin
        src_valid_out = 1'b0;
        src_hdr_out = '0;
        src_len_out = '0;
        src_pay_valid_out = 1'b0;
        src_pay_idx_out = '0;
        src_pay_data_out = '0;
        rep_valid_out = 1'b0;
        rep_hdr_out = '0;
        rep_pt_out = '0;
    end
    // ==========================================================
    // Packets; released header, length and payload data lines invert so stale data never matches
    task automatic send_src(input logic [63:0] h, input logic [15:0] l,
                            input logic [31:0] w0, w1, input int nw);
        for (int k = 0; k < nw; k++) begin
            @(posedge clk_in);
            src_pay_valid_out <= 1'b1;
            src_pay_idx_out <= 4'(k);
            src_pay_data_out <= (k != 0) ? w1 : w0;
        end
        @(posedge clk_in);
        src_pay_valid_out <= 1'b0;
        src_pay_data_out <= ~src_pay_data_out;
        src_valid_out <= 1'b1;
        src_hdr_out <= h;
        src_len_out <= l;
        @(posedge clk_in);
        src_valid_out <= 1'b0;
        src_hdr_out <= ~h;
        src_len_out <= ~l;
    endtask
    task automatic send_rep(input logic [223:0] h, input logic [6:0] pt);
        @(posedge clk_in);
        rep_valid_out <= 1'b1;
        rep_hdr_out <= h;
        rep_pt_out <= pt;
        @(posedge clk_in);
        rep_valid_out <= 1'b0;
        rep_hdr_out <= ~h;
    endtask
endmodule // pfrc_stream_model
